// *** pkg/flash_pkg.sv ***
/*
  Constants and types for the paged flash controller.
  Assumes a single 25 MHz system clock domain.
*/
package flash_pkg;
  localparam int ADDR_W = 14;
  localparam int PAGE_W = 5;
  localparam int OFFS_W = 9;
  localparam int PAGES = 32;
  localparam int BYTES = 16384;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] KEY_IDLE = 8'hff;
  // Key value is arbitrary
  localparam logic [7:0] OP_KEY = 8'h3b;
  localparam logic [7:0] CMD_WRITE = 8'h01;
  localparam logic [7:0] CMD_ERASE_PAGE = 8'h02;
  localparam logic [7:0] CMD_MASS_ERASE = 8'h03;
  localparam logic [7:0] CMD_VERIFY = 8'h04;
  localparam logic [7:0] CMD_READ = 8'h05;
  localparam logic [OFFS_W-1:0] OFFS_LAST = 9'h1ff;
  localparam logic [ADDR_W-1:0] ADDR_LAST = 14'h3fff;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 14'h0000;
  localparam int PROT_PAGE = 31;
  typedef enum logic [2:0] {ST_IDLE, ST_ERASE, ST_PROG, ST_CHECK, ST_READ} state_t;
endpackage

// *** design/paged_flash_controller.sv ***
/*
  Paged flash controller: 16 kB array in 32 pages of 512 bytes, key gated
  commands, page and mass erase, byte write, verify, read, W/E protection.
  Assumes the core drives the special function register writes as one-cycle
  strobes on CLK_I and holds its program counter while BUSY_O is high.
*/
`timescale 1ns/100ps
module paged_flash_controller (
  input wire logic CLK_I, // System clock, 25 MHz
  input wire logic RESET_I, // Synchronous reset, active high
  input wire logic KEY_WR_I, // Key register write strobe
  input wire logic CMD_WR_I, // Command register write strobe
  input wire logic DATA_WR_I, // Data register write strobe
  input wire logic ADDRH_WR_I, // High address register write strobe
  input wire logic ADDRL_WR_I, // Low address register write strobe
  input wire logic [7:0] WDATA_I, // Write data for all strobes
  input wire logic [flash_pkg::PAGES-1:0] PROT_WE_N_I, // Per-page W/E protect, low protects while bit 31 (PROT_PAGE) is also low
  output logic BUSY_O, // Operation in progress, stalls core
  output logic DONE_O, // One-cycle pulse at completion
  output logic REJECT_O, // Last command refused
  output logic VERIFY_OK_O, // Last verify matched
  output logic [7:0] READ_DATA_O, // Byte from last read
  output logic [7:0] KEY_O // Key register readback
);
  import flash_pkg::*;

  logic [7:0] mem [0:BYTES-1];
  logic [7:0] operation_key_reg;
  logic [7:0] flash_data_reg;
  logic [7:0] flash_addr_high;
  logic [7:0] flash_addr_low;
  logic [7:0] flash_command_reg;
  state_t state_reg;
  logic [ADDR_W-1:0] ptr_reg;
  logic [ADDR_W-1:0] end_reg;
  logic [ADDR_W-1:0] req_addr;
  logic [PAGE_W-1:0] req_page;
  logic [7:0] mem_q;
  logic prot_active;
  logic page_locked;
  logic any_locked;
  logic cmd_known;
  logic accept;
  logic refuse;
  logic finish;
  logic mem_we;
  logic [7:0] mem_wdata;

  assign req_addr = {flash_addr_high[ADDR_W-9:0], flash_addr_low};
  assign req_page = req_addr[ADDR_W-1:OFFS_W];
  assign mem_q = mem[ptr_reg];
  assign prot_active = ~PROT_WE_N_I[PROT_PAGE];
  assign page_locked = prot_active & ~PROT_WE_N_I[req_page];
  assign any_locked = prot_active & ~(&PROT_WE_N_I);
  assign cmd_known = (WDATA_I == CMD_WRITE) || (WDATA_I == CMD_ERASE_PAGE) ||
                     (WDATA_I == CMD_MASS_ERASE) || (WDATA_I == CMD_VERIFY) ||
                     (WDATA_I == CMD_READ);
  // Commands while busy are dropped without effect
  always_comb begin
    accept = 1'b0;
    refuse = 1'b0;
    if (CMD_WR_I && state_reg == ST_IDLE) begin
      if (operation_key_reg != OP_KEY || !cmd_known) begin
        refuse = 1'b1;
      end else if ((WDATA_I == CMD_WRITE || WDATA_I == CMD_ERASE_PAGE) && page_locked) begin
        refuse = 1'b1;
      end else if (WDATA_I == CMD_MASS_ERASE && any_locked) begin
        refuse = 1'b1;
      end else begin
        accept = 1'b1;
      end
    end
  end

  assign finish = (state_reg == ST_PROG) || (state_reg == ST_CHECK) ||
                  (state_reg == ST_READ) || (state_reg == ST_ERASE && ptr_reg == end_reg);

  // Only erase writes ones; programming ANDs, so zeros survive
  assign mem_we = (state_reg == ST_ERASE) || (state_reg == ST_PROG);
  assign mem_wdata = (state_reg == ST_ERASE) ? ERASED_BYTE :
                     (mem_q & flash_data_reg);

  always_ff @(posedge CLK_I) begin
    if (mem_we) begin
      mem[ptr_reg] <= mem_wdata;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      flash_data_reg <= 8'h00;
      flash_addr_high <= 8'h00;
      flash_addr_low <= 8'h00;
      flash_command_reg <= 8'h00;
    end else if (state_reg == ST_IDLE) begin
      if (DATA_WR_I) begin
        flash_data_reg <= WDATA_I;
      end
      if (ADDRH_WR_I) begin
        flash_addr_high <= WDATA_I;
      end
      if (ADDRL_WR_I) begin
        flash_addr_low <= WDATA_I;
      end
      if (accept) begin
        flash_command_reg <= WDATA_I;
      end
    end
  end

  // Key is consumed by any completed or refused command
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      operation_key_reg <= KEY_IDLE;
    end else if (finish || refuse) begin
      operation_key_reg <= KEY_IDLE;
    end else if (KEY_WR_I && state_reg == ST_IDLE && !CMD_WR_I) begin
      operation_key_reg <= WDATA_I;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      state_reg <= ST_IDLE;
      ptr_reg <= ADDR_ZERO;
      end_reg <= ADDR_ZERO;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (accept) begin
            ptr_reg <= req_addr;
            end_reg <= req_addr;
            case (WDATA_I)
              CMD_WRITE: state_reg <= ST_PROG;
              CMD_ERASE_PAGE: begin
                ptr_reg <= {req_page, {OFFS_W{1'b0}}};
                end_reg <= {req_page, OFFS_LAST};
                state_reg <= ST_ERASE;
              end
              CMD_MASS_ERASE: begin
                ptr_reg <= ADDR_ZERO;
                end_reg <= ADDR_LAST;
                state_reg <= ST_ERASE;
              end
              CMD_VERIFY: state_reg <= ST_CHECK;
              default: state_reg <= ST_READ;
            endcase
          end
        end
        ST_ERASE: begin
          if (ptr_reg == end_reg) begin
            state_reg <= ST_IDLE;
          end else begin
            ptr_reg <= ptr_reg + 14'h0001;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      BUSY_O <= 1'b0;
      DONE_O <= 1'b0;
      REJECT_O <= 1'b0;
      VERIFY_OK_O <= 1'b0;
      READ_DATA_O <= 8'h00;
      KEY_O <= KEY_IDLE;
    end else begin
      BUSY_O <= accept || (state_reg != ST_IDLE && !finish);
      DONE_O <= finish;
      KEY_O <= (finish || refuse) ? KEY_IDLE : operation_key_reg;
      if (refuse) begin
        REJECT_O <= 1'b1;
      end else if (accept) begin
        REJECT_O <= 1'b0;
      end
      if (state_reg == ST_CHECK) begin
        VERIFY_OK_O <= (mem_q == flash_data_reg);
      end
      if (state_reg == ST_READ) begin
        READ_DATA_O <= mem_q;
      end
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  erase_ones_a: assert property (state_reg == ST_ERASE |-> mem_wdata == ERASED_BYTE)
    else $error("Erase does not write ones");
  prog_and_a: assert property (state_reg == ST_PROG |-> (mem_wdata & ~mem_q) == 8'h00)
    else $error("Program sets a bit");
  no_byte_erase_a: assert property (accept && WDATA_I == CMD_ERASE_PAGE
      |=> ptr_reg[OFFS_W-1:0] == 9'h000 && end_reg[OFFS_W-1:0] == OFFS_LAST)
    else $error("Erase range is not a whole page");
  page_index_a: assert property (accept && WDATA_I == CMD_ERASE_PAGE
      |=> ptr_reg[ADDR_W-1:OFFS_W] == $past(req_page))
    else $error("Wrong page selected");
  mass_range_a: assert property (accept && WDATA_I == CMD_MASS_ERASE
      |=> ptr_reg == ADDR_ZERO && end_reg == ADDR_LAST)
    else $error("Mass erase range wrong");
  verify_result_a: assert property (state_reg == ST_CHECK
      |=> VERIFY_OK_O == ($past(mem_q) == $past(flash_data_reg)) && DONE_O)
    else $error("Verify result wrong");
  protect_block_a: assert property (CMD_WR_I && WDATA_I == CMD_WRITE && page_locked
      |-> !accept)
    else $error("Protected page accepted");
  cmd_latch_a: assert property (state_reg == ST_PROG |-> flash_command_reg == CMD_WRITE)
    else $error("Program without write command");
  key_clear_a: assert property (finish |=> operation_key_reg == KEY_IDLE)
    else $error("Key not cleared");
  stall_a: assert property (accept |=> BUSY_O [*2] or (BUSY_O ##1 DONE_O))
    else $error("Stall dropped early");
  write_cmd_a: assert property (accept && WDATA_I == CMD_WRITE |=> state_reg == ST_PROG)
    else $error("Write command not started");
  busy_ignore_a: assert property (state_reg != ST_IDLE |-> !accept && !refuse)
    else $error("Command taken while busy");
endmodule

// *** bench/core_model.sv ***
/*
  Core side model: issues register writes to the flash controller.
  Assumes strobes are sampled on the rising edge of clk_i.
*/
`timescale 1ns/100ps
module core_model (
  input wire logic clk_i, // System clock
  input wire logic done_i, // Completion pulse
  output logic [4:0] wr_o, // Key, command, data, high, low strobes
  output logic [7:0] wdata_o // Shared write data
);
  import flash_pkg::*;
  initial begin
    wr_o = 5'h00;
    wdata_o = 8'h00;
  end
  // Released data bus shows the inverse value
  task automatic sfr(input int sel, input logic [7:0] val);
    @(posedge clk_i);
    #1;
    wr_o = 5'(1 << sel);
    wdata_o = val;
    @(posedge clk_i);
    #1;
    wr_o = 5'h00;
    wdata_o = ~val;
  endtask
  task automatic op(input logic [7:0] cmd, input logic [13:0] a, input logic [7:0] d,
    input bit with_key, input int max, output bit got);
    int n;
    n = 0;
    if (with_key) begin
      sfr(0, OP_KEY);
    end
    sfr(2, d);
    sfr(3, {2'b00, a[13:8]});
    sfr(4, a[7:0]);
    sfr(1, cmd);
    while (done_i !== 1'b1 && n < max) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    got = (done_i === 1'b1);
  endtask
endmodule

// *** bench/paged_flash_controller_tb.sv ***
/*
  Self-checking bench for the paged flash controller with a byte model.
  Assumes the core model drives all register strobes.
*/
`timescale 1ns/100ps
module paged_flash_controller_tb;
  import flash_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] wr;
  logic [7:0] wdata, rdata, key, d;
  logic [PAGES-1:0] prot = '1;
  logic busy, done, rej, vok;
  logic [13:0] a, b;
  int err_count = 0;
  int checks = 0;
  int seed = 32'hb350;
  int mem [BYTES];
  bit ok;
  always #20 clk = ~clk;
  paged_flash_controller u_dut (.CLK_I(clk), .RESET_I(rst), .KEY_WR_I(wr[0]),
    .CMD_WR_I(wr[1]), .DATA_WR_I(wr[2]), .ADDRH_WR_I(wr[3]), .ADDRL_WR_I(wr[4]),
    .WDATA_I(wdata), .PROT_WE_N_I(prot), .BUSY_O(busy), .DONE_O(done), .REJECT_O(rej),
    .VERIFY_OK_O(vok), .READ_DATA_O(rdata), .KEY_O(key));
  core_model u_core (.clk_i(clk), .done_i(done), .wr_o(wr), .wdata_o(wdata));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("Mismatches %0d, checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic rd(input logic [13:0] ad);
    u_core.op(CMD_READ, ad, 8'h00, 1'b1, 20, ok);
    check(ok, 1'b1);
    check(rej, 1'b0);
    check(rdata, mem[ad][7:0]);
  endtask
  task automatic wrb(input logic [13:0] ad, input logic [7:0] dv);
    u_core.op(CMD_WRITE, ad, dv, 1'b1, 20, ok);
    mem[ad] = mem[ad] & dv;
    check(key, KEY_IDLE);
  endtask
  task automatic erase(input logic [7:0] c, input logic [13:0] ad);
    for (int i = 0; i < BYTES; i++) begin
      if (c == CMD_MASS_ERASE || i[13:9] == ad[13:9]) mem[i] = 32'hff;
    end
    u_core.op(c, ad, 8'h00, 1'b1, 17000, ok);
    check(ok, 1'b1);
  endtask
  initial begin
    #1600000;
    err_count++;
    test_done();
  end
  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    check(key, KEY_IDLE);
    erase(CMD_MASS_ERASE, ADDR_ZERO);
    for (int i = 0; i < 4; i++) rd(14'($random(seed)));
    a = 14'h0600 | 14'($random(seed) & 32'h1ff);
    b = a ^ 14'h0200;
    d = 8'($random(seed));
    wrb(a, d);
    wrb(a, ~d ^ 8'h0f);
    rd(a);
    wrb(b, 8'h00);
    u_core.op(CMD_VERIFY, a, mem[a][7:0], 1'b1, 20, ok);
    check(vok, 1'b1);
    u_core.op(CMD_VERIFY, a, mem[a][7:0] ^ 8'h01, 1'b1, 20, ok);
    check(vok, 1'b0);
    u_core.op(CMD_WRITE, b, 8'hff, 1'b0, 3, ok);
    check({rej, busy}, 2'b10);
    rd(b);
    u_core.op(8'h07, b, 8'h00, 1'b1, 3, ok);
    check({rej, key}, {1'b1, KEY_IDLE});
    prot = ~(32'h8000_0000 | (32'h1 << a[13:9]));
    u_core.op(CMD_WRITE, a, 8'h00, 1'b1, 3, ok);
    check(rej, 1'b1);
    rd(a);
    u_core.op(CMD_MASS_ERASE, a, 8'h00, 1'b1, 3, ok);
    check({rej, busy}, 2'b10);
    prot = '1;
    fork
      erase(CMD_ERASE_PAGE, a);
      begin
        repeat (100) @(posedge clk);
        #2 check(busy, 1'b1);
        u_core.sfr(0, 8'h00);
        check(key, OP_KEY);
      end
    join
    rd(a);
    rd(b);
    rd(ADDR_LAST);
    test_done();
  end
endmodule
